/* File: hdl/cmm_pkg.sv */
// Shared constants and types of the content-match search block.
// Assumes a single pclk domain and an APB master with 32-bit data.
`default_nettype none

package cmm_pkg;

	// Geometry, fixed at the documented sizes
	localparam int ENTRIES   = 32;
	localparam int AW        = 5;
	localparam int PAT_W     = 32;
	localparam int BLK_WORDS = 32;
	localparam int BLK_BITS  = 32;
	localparam int NUM_BLK   = ENTRIES / BLK_WORDS;
	localparam int CNT_W     = 6;

	// Search modes as written to the control register
	localparam logic [1:0] MODE_SINGLE = 2'h0;
	localparam logic [1:0] MODE_MULTI  = 2'h1;
	localparam logic [1:0] MODE_FAST   = 2'h2;
	localparam logic [1:0] CTRL_RST    = 2'h0;

	// Register byte offsets
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_WR_PAT = 8'h04;
	localparam logic [7:0] OFS_WR_MSK = 8'h08;
	localparam logic [7:0] OFS_WR_CMD = 8'h0c;
	localparam logic [7:0] OFS_KEY    = 8'h10;
	localparam logic [7:0] OFS_NEXT   = 8'h14;
	localparam logic [7:0] OFS_STATUS = 8'h18;
	localparam logic [7:0] OFS_MBITS  = 8'h1c;

	// Command register fields
	localparam int CMD_DC_BIT  = 8;
	localparam int CMD_DEL_BIT = 9;

	// Status register fields
	localparam int ST_FOUND  = 0;
	localparam int ST_RDBUSY = 1;
	localparam int ST_WRBUSY = 2;
	localparam int ST_MODE   = 4;
	localparam int ST_ADDR   = 8;
	localparam int ST_COUNT  = 16;

	// Write hold counts, in pclk cycles
	localparam logic [1:0] WR_CYC_PLAIN = 2'h2;
	localparam logic [1:0] WR_CYC_DC    = 2'h3;

	typedef struct packed {
		logic             del;
		logic [AW-1:0]    addr;
		logic [PAT_W-1:0] pat;
		logic [PAT_W-1:0] care;
	} cmm_wr_t;

	typedef struct packed {
		logic          found;
		logic [AW-1:0] addr;
	} cmm_hit_t;

endpackage

`default_nettype wire

/* File: hdl/cmm_store.sv */
// Entry store and match lines of the content-match search block.
// Assumes the owner sequences writes and selects full or half compares.
`timescale 1ns/100ps
`default_nettype none

module cmm_store import cmm_pkg::*; (
	// Clock and reset
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	// Write port
	input  wire logic                 we,
	input  wire cmm_wr_t              wr,
	// Compare port
	input  wire logic [PAT_W-1:0]     key,
	input  wire logic [PAT_W-1:0]     cmp_mask,
	input  wire logic                 full_en,
	input  wire logic                 half_en,
	input  wire logic                 odd,
	// Registered match lines
	output logic      [ENTRIES-1:0]   lines_q
);

	logic [PAT_W-1:0]   val_q  [ENTRIES];
	logic [PAT_W-1:0]   care_q [ENTRIES];
	logic [ENTRIES-1:0] vld_q;
	logic [ENTRIES-1:0] hit_w;

	// Each group of BLK_WORDS entries is one embedded_memory_block slice
	for (genvar b = 0; b < NUM_BLK; b++) begin : g_blk
		for (genvar w = 0; w < BLK_WORDS; w++) begin : g_word
			// Care bit of zero lets the stored bit match either value
			assign hit_w[b*BLK_WORDS+w] = vld_q[b*BLK_WORDS+w] &
				~|((val_q[b*BLK_WORDS+w] ^ key) & care_q[b*BLK_WORDS+w] & cmp_mask);
		end
	end

	// Array contents need no reset; only the valid bits gate matching
	always_ff @(posedge pclk) begin
		if (we && !wr.del) begin
			val_q[wr.addr]  <= wr.pat;
			care_q[wr.addr] <= wr.care;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			vld_q <= '0;
		end else if (we) begin
			vld_q[wr.addr] <= ~wr.del;
		end
	end

	// Half mode refreshes even entries, then odd ones
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lines_q <= '0;
		end else begin
			for (int i = 0; i < ENTRIES; i++) begin
				if (full_en || (half_en && (i[0] == odd))) begin
					lines_q[i] <= hit_w[i];
				end
			end
		end
	end

endmodule // cmm_store

`default_nettype wire

/* File: hdl/cmm_top.sv */
// Content-match search block with an APB register interface.
// Assumes an APB master on pclk; all entries and searches pass the registers.
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - Single mode spans depths beyond 32 entries by grouping memory blocks.
// - Pattern widths above 32 bits force fast multiple-match mode.
// - A set mask bit makes the stored bit match either value.
// - Multiple-match search takes two cycles, half the lines each cycle.
// - A hit raises found and shows the lowest matching address.
// - Multiple modes give the match vector and the total count.
// - Multiple-match mode compares only the low 31 pattern bits.
// - Multiple mode grows deeper by cascading blocks; wider patterns force fast mode.
// - Fast mode behaves like multiple mode with one-cycle results and all 32 pattern bits compared.
// - Fast mode never raises read busy.
// - Multiple and fast modes step addresses by start and next; single mode does not step.
// - Fast mode grows deeper and wider by cascading blocks.
// - Mask bits are stored only when don't-care use is flagged.
// - Delete removes the entry at the write address.
// - Single mode searches in one cycle and never steps matches.
// - Delete lasts two cycles and ignores pattern and mask.
// - Single mode count shows only zero or one.
// - Next advances the shown address to the next match.
module cmm_top import cmm_pkg::*; (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr
);

	typedef enum logic [1:0] {S_IDLE, S_ONE, S_EVEN, S_ODD} cmm_state_t;

	// Lowest set line of a vector
	function automatic cmm_hit_t lowest(input logic [ENTRIES-1:0] v);
		cmm_hit_t h;
		h = '0;
		for (int i = ENTRIES - 1; i >= 0; i--) begin
			if (v[i]) begin
				h.found = 1'b1;
				h.addr  = AW'(i);
			end
		end
		return h;
	endfunction

	// Lines at or above an index; an index of ENTRIES gives none
	function automatic logic [ENTRIES-1:0] at_or_above(input logic [AW:0] idx);
		logic [ENTRIES-1:0] m;
		m = '0;
		for (int i = 0; i < ENTRIES; i++) begin
			m[i] = (i >= int'(idx));
		end
		return m;
	endfunction

	function automatic logic [CNT_W-1:0] popcount(input logic [ENTRIES-1:0] v);
		logic [CNT_W-1:0] c;
		c = '0;
		for (int i = 0; i < ENTRIES; i++) begin
			c = c + CNT_W'(v[i]);
		end
		return c;
	endfunction

	// Mode actually used; wide patterns cannot run the other modes
	function automatic logic [1:0] eff_mode(input logic [1:0] m);
		if (PAT_W > BLK_BITS) begin
			return MODE_FAST;
		end else if (m == MODE_MULTI || m == MODE_FAST) begin
			return m;
		end else begin
			return MODE_SINGLE;
		end
	endfunction

	// Registers
	logic [1:0]         mode_q;
	logic [PAT_W-1:0]   pat_q;
	logic [PAT_W-1:0]   msk_q;
	logic [AW-1:0]      cmd_addr_q;
	logic               cmd_dc_q;
	logic               cmd_del_q;
	logic [PAT_W-1:0]   key_q;
	logic [1:0]         wr_cnt_q;
	cmm_wr_t            wr_req_q;
	cmm_state_t         state_q;
	logic [1:0]         srch_mode_q;
	logic               done_q;
	logic [AW-1:0]      floor_q;
	logic [31:0]        prdata_q;

	// Store connections
	logic [ENTRIES-1:0] lines_w;
	logic [PAT_W-1:0]   cmp_mask_w;
	logic               store_we_w;
	logic               full_en_w;
	logic               half_en_w;
	logic               odd_w;

	// APB decode
	logic               setup_w;
	logic               wr_acc_w;
	logic               rd_setup_w;
	logic               sel_ctrl_w;
	logic               sel_pat_w;
	logic               sel_msk_w;
	logic               sel_cmd_w;
	logic               sel_key_w;
	logic               sel_next_w;
	logic               sel_stat_w;
	logic               sel_mbits_w;
	logic               mapped_w;

	assign setup_w     = psel & ~penable;
	assign wr_acc_w    = psel & penable & pwrite;
	assign rd_setup_w  = setup_w & ~pwrite;
	assign sel_ctrl_w  = (paddr == OFS_CTRL);
	assign sel_pat_w   = (paddr == OFS_WR_PAT);
	assign sel_msk_w   = (paddr == OFS_WR_MSK);
	assign sel_cmd_w   = (paddr == OFS_WR_CMD);
	assign sel_key_w   = (paddr == OFS_KEY);
	assign sel_next_w  = (paddr == OFS_NEXT);
	assign sel_stat_w  = (paddr == OFS_STATUS);
	assign sel_mbits_w = (paddr == OFS_MBITS);
	assign mapped_w    = sel_ctrl_w | sel_pat_w | sel_msk_w | sel_cmd_w |
	                     sel_key_w | sel_next_w | sel_stat_w | sel_mbits_w;

	// Zero wait states; unmapped offsets answer with an error
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~mapped_w;
	assign prdata  = prdata_q;

	// Write sequencing
	logic               wr_busy_w;
	logic               start_wr_w;

	assign wr_busy_w  = (wr_cnt_q != 2'h0);
	assign start_wr_w = wr_acc_w & sel_cmd_w & ~wr_busy_w;
	// Entry is committed in the last held cycle
	assign store_we_w = (wr_cnt_q == 2'h1);

	// Search sequencing
	logic               rd_busy_w;
	logic               start_srch_w;
	logic               next_w;
	logic               multi_w;
	cmm_hit_t           cur_w;
	cmm_hit_t           nxt_w;
	logic               found_w;
	logic [CNT_W-1:0]   count_w;
	logic [ENTRIES-1:0] mbits_w;

	// Read busy exists only for the two-cycle mode
	assign rd_busy_w    = (state_q == S_EVEN) | (state_q == S_ODD);
	assign start_srch_w = wr_acc_w & sel_key_w & (state_q == S_IDLE);
	assign multi_w      = (srch_mode_q != MODE_SINGLE);
	// Single mode has no stepping, so next is dropped there
	assign next_w       = wr_acc_w & sel_next_w & (state_q == S_IDLE) & done_q & multi_w;
	assign full_en_w    = (state_q == S_ONE);
	assign half_en_w    = rd_busy_w;
	assign odd_w        = (state_q == S_ODD);
	// Top pattern bit of each block is left out of the compare in this mode
	assign cmp_mask_w   = (srch_mode_q == MODE_MULTI) ? {1'b0, {(PAT_W-1){1'b1}}} : '1;

	assign mbits_w = done_q ? lines_w : '0;
	assign cur_w   = lowest(mbits_w & at_or_above({1'b0, floor_q}));
	assign nxt_w   = lowest(mbits_w & at_or_above({1'b0, cur_w.addr} + 6'h01));
	assign found_w = cur_w.found;
	// Single mode reports presence only
	assign count_w = multi_w ? popcount(mbits_w) : CNT_W'(|mbits_w);

	cmm_store u_store (
		.pclk     (pclk),
		.presetn  (presetn),
		.we       (store_we_w),
		.wr       (wr_req_q),
		.key      (key_q),
		.cmp_mask (cmp_mask_w),
		.full_en  (full_en_w),
		.half_en  (half_en_w),
		.odd      (odd_w),
		.lines_q  (lines_w)
	);

	// Software-visible settings
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_q <= CTRL_RST;
			pat_q  <= '0;
			msk_q  <= '0;
		end else if (wr_acc_w) begin
			if (sel_ctrl_w) begin
				mode_q <= pwdata[1:0];
			end
			if (sel_pat_w) begin
				pat_q <= pwdata[PAT_W-1:0];
			end
			if (sel_msk_w) begin
				msk_q <= pwdata[PAT_W-1:0];
			end
		end
	end

	// Commands arriving while busy are dropped
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_cnt_q   <= 2'h0;
			wr_req_q   <= '0;
			cmd_addr_q <= '0;
			cmd_dc_q   <= 1'b0;
			cmd_del_q  <= 1'b0;
		end else if (start_wr_w) begin
			cmd_addr_q    <= pwdata[AW-1:0];
			cmd_dc_q      <= pwdata[CMD_DC_BIT];
			cmd_del_q     <= pwdata[CMD_DEL_BIT];
			wr_req_q.addr <= pwdata[AW-1:0];
			wr_req_q.del  <= pwdata[CMD_DEL_BIT];
			wr_req_q.pat  <= pat_q;
			// Mask taken only with don't-care use; deletes never look at it
			wr_req_q.care <= pwdata[CMD_DC_BIT] ? ~msk_q : '1;
			if (pwdata[CMD_DC_BIT] && !pwdata[CMD_DEL_BIT]) begin
				wr_cnt_q <= WR_CYC_DC;
			end else begin
				wr_cnt_q <= WR_CYC_PLAIN;
			end
		end else if (wr_busy_w) begin
			wr_cnt_q <= wr_cnt_q - 2'h1;
		end
	end

	// Search control
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q     <= S_IDLE;
			srch_mode_q <= MODE_SINGLE;
			key_q       <= '0;
			done_q      <= 1'b0;
		end else begin
			case (state_q)
				S_IDLE: begin
					if (start_srch_w) begin
						key_q       <= pwdata[PAT_W-1:0];
						srch_mode_q <= eff_mode(mode_q);
						done_q      <= 1'b0;
						if (eff_mode(mode_q) == MODE_MULTI) begin
							state_q <= S_EVEN;
						end else begin
							state_q <= S_ONE;
						end
					end
				end
				S_ONE: begin
					state_q <= S_IDLE;
					done_q  <= 1'b1;
				end
				S_EVEN: begin
					state_q <= S_ODD;
				end
				S_ODD: begin
					state_q <= S_IDLE;
					done_q  <= 1'b1;
				end
				default: begin
					state_q <= S_IDLE;
				end
			endcase
		end
	end

	// Address cursor; stepping stops on the last match
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			floor_q <= '0;
		end else if (start_srch_w) begin
			floor_q <= '0;
		end else if (next_w && nxt_w.found) begin
			floor_q <= nxt_w.addr;
		end
	end

	// Read data captured in the setup cycle, stable in the access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= '0;
		end else if (rd_setup_w) begin
			prdata_q <= '0;
			if (sel_ctrl_w) begin
				prdata_q[1:0] <= mode_q;
			end
			if (sel_pat_w) begin
				prdata_q[PAT_W-1:0] <= pat_q;
			end
			if (sel_msk_w) begin
				prdata_q[PAT_W-1:0] <= msk_q;
			end
			if (sel_cmd_w) begin
				prdata_q[AW-1:0]        <= cmd_addr_q;
				prdata_q[CMD_DC_BIT]  <= cmd_dc_q;
				prdata_q[CMD_DEL_BIT] <= cmd_del_q;
			end
			if (sel_key_w) begin
				prdata_q[PAT_W-1:0] <= key_q;
			end
			if (sel_stat_w) begin
				prdata_q[ST_FOUND]                <= found_w;
				prdata_q[ST_RDBUSY]               <= rd_busy_w;
				prdata_q[ST_WRBUSY]               <= wr_busy_w;
				prdata_q[ST_MODE+1:ST_MODE]       <= eff_mode(mode_q);
				prdata_q[ST_ADDR+AW-1:ST_ADDR]    <= cur_w.addr;
				prdata_q[ST_COUNT+CNT_W-1:ST_COUNT] <= count_w;
			end
			if (sel_mbits_w) begin
				prdata_q[ENTRIES-1:0] <= mbits_w;
			end
		end
	end

endmodule // cmm_top

`default_nettype wire

/* File: tb/cmm_chk.sv */
// Port-level checker for the content-match search block.
// Assumes it is bound to cmm_top and sees only its APB ports.
`timescale 1ns/100ps
`default_nettype none

module cmm_chk import cmm_pkg::*; (
	// Clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// APB slave
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	wire       acc_w  = psel && penable && pwrite;
	wire       key_w  = acc_w && paddr == OFS_KEY;
	wire       cmd_w  = acc_w && paddr == OFS_WR_CMD;
	wire [1:0] mode_w = (pwdata[1:0] == 2'h3) ? MODE_SINGLE : pwdata[1:0];
	wire [5:0] cnt_w  = prdata[ST_COUNT +: CNT_W];
	logic [1:0] ctrl_q;
	logic [1:0] srch_q;
	logic [2:0] k_q;
	logic [2:0] w_q;
	logic       dc_q;

	// Saturating ages of the last search and the last write command
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= MODE_SINGLE;
			srch_q <= MODE_SINGLE;
			k_q    <= 3'h7;
			w_q    <= 3'h7;
			dc_q   <= 1'b0;
		end else begin
			if (acc_w && paddr == OFS_CTRL)
				ctrl_q <= mode_w;
			if (key_w)
				srch_q <= ctrl_q;
			k_q  <= key_w ? 3'h0 : k_q + {2'h0, k_q != 3'h7};
			w_q  <= cmd_w ? 3'h0 : w_q + {2'h0, w_q != 3'h7};
			dc_q <= cmd_w ? pwdata[CMD_DC_BIT] && !pwdata[CMD_DEL_BIT] : dc_q;
		end
	end

	sequence s_stat;
		psel && penable && !pwrite && paddr == OFS_STATUS;
	endsequence
	sequence s_multi_key;
		key_w && ctrl_q == MODE_MULTI;
	endsequence
	sequence s_stat_next;
		psel && !penable && !pwrite && paddr == OFS_STATUS ##1 penable;
	endsequence

	property p_busy_on;
		s_multi_key ##1 s_stat_next |-> prdata[ST_RDBUSY];
	endproperty
	property p_busy_off;
		s_stat ##0 k_q >= 3'h4 |-> !prdata[ST_RDBUSY];
	endproperty
	property p_fast_idle;
		s_stat ##0 srch_q == MODE_FAST |-> !prdata[ST_RDBUSY];
	endproperty
	property p_single_idle;
		s_stat ##0 srch_q == MODE_SINGLE |-> !prdata[ST_RDBUSY];
	endproperty
	property p_single_cnt;
		s_stat ##0 srch_q == MODE_SINGLE |-> cnt_w <= 6'h1;
	endproperty
	property p_nohit;
		s_stat ##0 !prdata[ST_FOUND] |-> cnt_w == 6'h0;
	endproperty
	property p_hit;
		s_stat ##0 prdata[ST_FOUND] |-> cnt_w != 6'h0;
	endproperty
	property p_wr_done;
		s_stat ##0 w_q >= 3'h3 + {2'h0, dc_q} |-> !prdata[ST_WRBUSY];
	endproperty
	property p_mode;
		s_stat |-> prdata[ST_MODE +: 2] == ctrl_q;
	endproperty

	a_busy_on: assert property (p_busy_on) else $error("rd busy low right after multi search");
	a_busy_off: assert property (p_busy_off) else $error("rd busy stuck after search");
	a_fast_idle: assert property (p_fast_idle) else $error("rd busy in fast mode");
	a_single_idle: assert property (p_single_idle) else $error("rd busy in single mode");
	a_single_cnt: assert property (p_single_cnt) else $error("single count above one");
	a_nohit: assert property (p_nohit) else $error("count without found");
	a_hit: assert property (p_hit) else $error("found with zero count");
	a_wr_done: assert property (p_wr_done) else $error("wr busy too long");
	a_mode: assert property (p_mode) else $error("effective mode differs");
endmodule // cmm_chk

`default_nettype wire

/* File: tb/cmm_apb_bfm.sv */
// APB master model standing for the user logic of the search block.
// Assumes callers enter tasks just after a rising pclk edge.
`timescale 1ns/100ps
`default_nettype none

module cmm_apb_bfm (
	// Clock
	input  wire logic        pclk,
	// APB master
	output var  logic        psel,
	output var  logic        penable,
	output var  logic        pwrite,
	output var  logic [7:0]  paddr,
	output var  logic [31:0] pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	initial begin
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 8'h00;
		pwdata  = 32'h0;
	end

	// Leaves the bus held, so a second call may follow back to back
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
	endtask

	// Released address and data lines show the inverse, never the stale value
	task automatic idle();
		psel    <= 1'b0;
		penable <= 1'b0;
		paddr   <= ~paddr;
		pwdata  <= ~pwdata;
		@(posedge pclk);
	endtask
endmodule // cmm_apb_bfm

`default_nettype wire

/* File: tb/cmm_top_test.sv */
// Self-checking bench of the content-match search block over APB.
// Assumes cmm_top, cmm_chk and cmm_apb_bfm are compiled before it.
`timescale 1ns/100ps
`default_nettype none

`define CHK(nm, x, y) begin check_count++; if ((y) !== (x)) begin mismatches++; $display("Error %s exp %0h got %0h", nm, x, y); end end

module cmm_top_test import cmm_pkg::*;;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [31:0] r;
	logic [31:0] st;
	logic        e;
	logic [1:0]  md;
	int          mismatches;
	int          check_count;
	int          cyc;

	cmm_apb_bfm bfm (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	cmm_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

	always #2.5 pclk = ~pclk;

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Cut a hang short well past the expected few hundred cycles
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			mismatches++;
			wrap_up();
		end
	end

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bfm.xfer(1'b1, a, d, r, e);
		bfm.idle();
	endtask

	task automatic rd(input logic [7:0] a);
		bfm.xfer(1'b0, a, 32'h0, r, e);
		bfm.idle();
	endtask

	task automatic put(input logic [4:0] a, input logic [31:0] p, input logic [31:0] m, input logic dc,
		input logic del);
		int n;
		n = 0;
		wr(OFS_WR_PAT, p);
		wr(OFS_WR_MSK, m);
		wr(OFS_WR_CMD, {22'h0, del, dc, 3'h0, a});
		do begin
			rd(OFS_STATUS);
			n++;
		end while (r[ST_WRBUSY] !== 1'b0 && n < 20);
		`CHK("wr busy", 1'b0, r[ST_WRBUSY])
	endtask

	// Status is read back to back with the key write
	task automatic find(input logic [31:0] k, input logic [1:0] m);
		int n;
		n = 0;
		bfm.xfer(1'b1, OFS_KEY, k, r, e);
		bfm.xfer(1'b0, OFS_STATUS, 32'h0, r, e);
		bfm.idle();
		`CHK("early busy", m == MODE_MULTI, r[ST_RDBUSY])
		// First read is captured before the compare edge; always read again
		do begin
			rd(OFS_STATUS);
			n++;
		end while (r[ST_RDBUSY] !== 1'b0 && n < 20);
		`CHK("rd busy", 1'b0, r[ST_RDBUSY])
		st = r;
	endtask

	task automatic chk_hit(input logic f, input logic [4:0] a, input logic [5:0] c, input logic [31:0] v);
		`CHK("found", f, st[ST_FOUND])
		if (f)
			`CHK("addr", a, st[ST_ADDR +: AW])
		`CHK("count", c, st[ST_COUNT +: CNT_W])
		rd(OFS_MBITS);
		`CHK("vector", v, r)
	endtask

	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		mismatches = 0;
		check_count = 0;
		cyc = 0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(OFS_CTRL);
		`CHK("ctrl reset", 32'h0, r)
		rd(OFS_STATUS);
		`CHK("status reset", 32'h0, r)
		rd(8'h20);
		`CHK("unmapped err", 1'b1, e)
		`CHK("unmapped data", 32'h0, r)
		$display("test registers done");
		// Entries kept unique per key in single mode
		put(5'h2, 32'h6, 32'h4, 1'b1, 1'b0);
		put(5'h3, 32'h10, 32'hf, 1'b0, 1'b0);
		find(32'h6, MODE_SINGLE);
		chk_hit(1'b1, 5'h2, 6'h1, 32'h4);
		find(32'h2, MODE_SINGLE);
		chk_hit(1'b1, 5'h2, 6'h1, 32'h4);
		wr(OFS_NEXT, 32'h0);
		rd(OFS_STATUS);
		`CHK("single next", 5'h2, r[ST_ADDR +: AW])
		find(32'h1f, MODE_SINGLE);
		chk_hit(1'b0, 5'h0, 6'h0, 32'h0);
		$display("test single done");
		put(5'h6, 32'h1, 32'h0, 1'b0, 1'b0);
		put(5'ha, 32'h1, 32'h0, 1'b0, 1'b0);
		put(5'h14, 32'h8000_0001, 32'h0, 1'b0, 1'b0);
		for (int i = 0; i < 2; i++) begin
			md = i ? MODE_FAST : MODE_MULTI;
			wr(OFS_CTRL, {30'h0, md});
			rd(OFS_STATUS);
			`CHK("mode", md, r[ST_MODE +: 2])
			find(32'h1, md);
			chk_hit(1'b1, 5'h6, i ? 6'h2 : 6'h3, i ? 32'h0000_0440 : 32'h0010_0440);
			for (int j = 0; j < 3; j++) begin
				wr(OFS_NEXT, 32'h0);
				rd(OFS_STATUS);
				`CHK("next addr", (j == 0 || i) ? 5'ha : 5'h14, r[ST_ADDR +: AW])
			end
			$display("test mode %0d done", md);
		end
		put(5'ha, 32'hdead_beef, 32'hffff_ffff, 1'b1, 1'b1);
		find(32'h1, MODE_FAST);
		chk_hit(1'b1, 5'h6, 6'h1, 32'h40);
		$display("test delete done");
		wrap_up();
	end
endmodule // cmm_top_test

bind cmm_top cmm_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

`default_nettype wire
